/* lxf_framer.v */
// Purpose: lap framer, deframer and rate gate behind an APB slave
// Assumes: serial clocks are slow pins sampled by pclk; bsync marks bit one
// Notes: received fcs octets are forwarded ahead of the end marker
`timescale 1ns/1ps
`include "lxf_defs.vh"
module lxf_framer
#(
	parameter TICK_CYCLES = `LXF_TICK_CYCLES
)
(
	// apb
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// frames from the mac queue
	input  wire        txq_valid,
	input  wire [7:0]  txq_data,
	input  wire        txq_last,
	input  wire [15:0] txq_level,
	output wire        txq_ready,
	output wire        tx_frame_req,
	output wire        eth_flow_ctrl,
	// frames to the mac queue
	output reg         rxq_valid,
	output reg  [7:0]  rxq_data,
	output reg         rxq_last,
	output reg         rxq_abort,
	// serial line
	input  wire        tx_clk,
	output reg         tx_data_q,
	output reg         tx_bsync_q,
	input  wire        rx_clk,
	input  wire        rx_data,
	input  wire        rx_bsync
);
	localparam ST_IDLE  = 3'h0;
	localparam ST_HDR   = 3'h1;
	localparam ST_BODY  = 3'h2;
	localparam ST_FCS   = 3'h3;
	localparam ST_CLOSE = 3'h4;
	localparam RS_HUNT  = 1'b0;
	localparam RS_IN    = 1'b1;

	reg  [1:0]  ctrl_q;
	reg  [31:0] hdr_q;
	reg  [6:0]  cir_q;
	reg  [15:0] wmark_q;
	reg  [15:0] rx_good_q;
	reg  [15:0] rx_abort_q;
	reg  [2:0]  tx_sync_q;
	reg  [2:0]  rx_sync_q;
	reg  [1:0]  rxd_sync_q;
	reg  [1:0]  rxb_sync_q;
	reg  [42:0] tx_scr_q;
	reg  [42:0] rx_scr_q;
	reg  [2:0]  tx_st_q;
	reg  [2:0]  tx_idx_q;
	reg  [7:0]  tx_sh_q;
	reg  [2:0]  tx_bit_q;
	reg         tx_esc_q;
	reg  [7:0]  tx_esc_byte_q;
	reg  [15:0] tx_len_q;
	reg         rx_st_q;
	reg         rx_esc_q;
	reg  [7:0]  rx_sh_q;
	reg  [2:0]  rx_bit_q;
	reg  [15:0] rx_cnt_q;
	reg         rx_bad_q;
	reg  [7:0]  tx_raw;
	reg  [7:0]  tx_out;
	reg         tx_crc_en;
	reg  [7:0]  rx_byte;
	wire        wr_en;
	wire        rd_en;
	wire        hit;
	wire        tx_edge;
	wire        rx_edge;
	wire        tx_load;
	wire        tx_start;
	wire        tx_line_bit;
	wire        rx_line_bit;
	wire        rx_clear_bit;
	wire        rx_byte_ev;
	wire        rx_data_ev;
	wire        rx_end;
	wire        rx_abort_ev;
	wire        rx_hdr_bad;
	wire [31:0] tx_crc;
	wire        rx_crc_good;
	wire [23:0] credit;
	wire        credit_ok;
	wire        laps_mode_enable;
	wire        scr_en;
	wire [7:0]  laps_expected_address;
	wire [7:0]  laps_expected_control;
	wire [7:0]  laps_expected_sapi_high;
	wire [7:0]  laps_expected_sapi_low;

	// header field of a given index
	function [7:0] lxf_hdr_byte;
		input [31:0] h;
		input [2:0]  idx;
		begin
			case (idx[1:0])
				2'h0:    lxf_hdr_byte = h[7:0];
				2'h1:    lxf_hdr_byte = h[15:8];
				2'h2:    lxf_hdr_byte = h[23:16];
				default: lxf_hdr_byte = h[31:24];
			endcase
		end
	endfunction

	assign laps_mode_enable        = ctrl_q[`LXF_CTRL_LAPS];
	assign scr_en                  = ctrl_q[`LXF_CTRL_SCR];
	assign laps_expected_address   = hdr_q[7:0];
	assign laps_expected_control   = hdr_q[15:8];
	assign laps_expected_sapi_high = hdr_q[23:16];
	assign laps_expected_sapi_low  = hdr_q[31:24];

	// apb decode, zero wait states
	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & ~pwrite;
	assign hit     = (paddr == `LXF_OFF_CTRL) | (paddr == `LXF_OFF_HDR) |
		(paddr == `LXF_OFF_CIR) | (paddr == `LXF_OFF_WMARK) |
		(paddr == `LXF_OFF_CREDIT) | (paddr == `LXF_OFF_RXSTAT);
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;

	// register writes
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q  <= `LXF_RST_CTRL;
			hdr_q   <= `LXF_RST_HDR;
			cir_q   <= `LXF_RST_CIR;
			wmark_q <= `LXF_RST_WMARK;
		end
		else if (wr_en)
		begin
			case (paddr)
				`LXF_OFF_CTRL:  ctrl_q  <= pwdata[1:0];
				`LXF_OFF_HDR:   hdr_q   <= pwdata;
				// [RULE_15] clamp to 52 Mbps
				`LXF_OFF_CIR:   cir_q   <= (pwdata[6:0] > `LXF_CIR_MAX) ?
					`LXF_CIR_MAX : pwdata[6:0];
				`LXF_OFF_WMARK: wmark_q <= pwdata[15:0];
				default:        ;
			endcase
		end
	end

	// read data, registered in setup cycle
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (rd_en & ~penable)
		begin
			case (paddr)
				`LXF_OFF_CTRL:   prdata <= {30'h0000000, ctrl_q};
				`LXF_OFF_HDR:    prdata <= hdr_q;
				`LXF_OFF_CIR:    prdata <= {25'h000000, cir_q};
				`LXF_OFF_WMARK:  prdata <= {16'h0000, wmark_q};
				`LXF_OFF_CREDIT: prdata <= {8'h00, credit};
				`LXF_OFF_RXSTAT: prdata <= {rx_abort_q, rx_good_q};
				default:         prdata <= 32'h00000000;
			endcase
		end
	end

	// [RULE_22] watermark flow control
	assign eth_flow_ctrl = (txq_level >= wmark_q);

	// pin synchronisers and edge finders
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_sync_q  <= 3'h0;
			rx_sync_q  <= 3'h0;
			rxd_sync_q <= 2'h0;
			rxb_sync_q <= 2'h0;
		end
		else
		begin
			tx_sync_q  <= {tx_sync_q[1:0], tx_clk};
			rx_sync_q  <= {rx_sync_q[1:0], rx_clk};
			rxd_sync_q <= {rxd_sync_q[0], rx_data};
			rxb_sync_q <= {rxb_sync_q[0], rx_bsync};
		end
	end
	assign tx_edge = tx_sync_q[1] & ~tx_sync_q[2];
	assign rx_edge = rx_sync_q[1] & ~rx_sync_q[2];

	// [RULE_14] credit gates only the mac-to-serial path
	lxf_cir #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_cir (
		.pclk        (pclk),
		.presetn     (presetn),
		.cir         (cir_q),
		.debit       (tx_load & ~tx_esc_q & (tx_st_q == ST_CLOSE)),
		.debit_bytes (tx_len_q),
		.credit_q    (credit),
		.credit_ok   (credit_ok)
	);

	// transmit: new octet needed at byte boundary
	assign tx_load  = tx_edge & (tx_bit_q == 3'h0);
	// [RULE_16] [RULE_20] no request without credit
	assign tx_frame_req = laps_mode_enable & credit_ok & (tx_st_q == ST_IDLE);
	// [RULE_01] lap frames only in laps mode
	assign tx_start = tx_frame_req & txq_valid;
	assign txq_ready = tx_load & ~tx_esc_q & (tx_st_q == ST_BODY);

	// [RULE_02] [RULE_03] octet before escaping, fcs over raw octets
	always @*
	begin
		tx_raw    = `LXF_FLAG;
		tx_crc_en = 1'b0;
		case (tx_st_q)
			ST_HDR:
			begin
				tx_raw    = lxf_hdr_byte(hdr_q, tx_idx_q);
				tx_crc_en = tx_load & ~tx_esc_q;
			end
			ST_BODY:
			begin
				tx_raw    = txq_data;
				tx_crc_en = tx_load & ~tx_esc_q;
			end
			ST_FCS:  tx_raw = lxf_hdr_byte(~tx_crc, tx_idx_q);
			default: tx_raw = `LXF_FLAG;
		endcase
		// [RULE_04] transparency escape
		if (tx_esc_q)
			tx_out = tx_esc_byte_q;
		else if (((tx_st_q == ST_HDR) | (tx_st_q == ST_BODY) | (tx_st_q == ST_FCS)) &
			((tx_raw == `LXF_FLAG) | (tx_raw == `LXF_ESC)))
			tx_out = `LXF_ESC;
		else
			tx_out = tx_raw;
	end

	lxf_crc32 u_tx_crc (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (tx_start & tx_load),
		.en      (tx_crc_en),
		.din     (tx_raw),
		.crc_q   (tx_crc),
		.good    ()
	);

	// transmit sequencer
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_st_q       <= ST_IDLE;
			tx_idx_q      <= 3'h0;
			tx_esc_q      <= 1'b0;
			tx_esc_byte_q <= 8'h00;
			tx_len_q      <= 16'h0000;
		end
		else if (tx_load)
		begin
			if (tx_esc_q)
				tx_esc_q <= 1'b0;
			else
			begin
				if ((tx_out == `LXF_ESC) & (tx_st_q != ST_IDLE) & (tx_st_q != ST_CLOSE))
				begin
					tx_esc_q      <= 1'b1;
					tx_esc_byte_q <= tx_raw ^ `LXF_ESC_XOR;
				end
				case (tx_st_q)
					ST_IDLE:
					if (tx_start)
					begin
						tx_st_q  <= ST_HDR;
						tx_idx_q <= 3'h0;
						tx_len_q <= 16'h0000;
					end
					ST_HDR:
					begin
						tx_idx_q <= tx_idx_q + 3'h1;
						if (tx_idx_q == `LXF_HDR_OCTETS - 3'h1)
							tx_st_q <= ST_BODY;
					end
					ST_BODY:
					begin
						tx_len_q <= tx_len_q + 16'h0001;
						tx_idx_q <= 3'h0;
						if (txq_last)
							tx_st_q <= ST_FCS;
					end
					ST_FCS:
					begin
						tx_idx_q <= tx_idx_q + 3'h1;
						if (tx_idx_q == `LXF_HDR_OCTETS - 3'h1)
							tx_st_q <= ST_CLOSE;
					end
					// [RULE_05] single closing flag
					default: tx_st_q <= ST_IDLE;
				endcase
			end
		end
	end

	// [RULE_23] free-running x^43+1 scrambler, never cleared
	assign tx_line_bit = tx_load ? tx_out[7] : tx_sh_q[7];
	always @(posedge pclk)
	begin
		if (tx_edge & scr_en)
			tx_scr_q <= {tx_scr_q[41:0], tx_line_bit ^ tx_scr_q[42]};
	end

	// transmit shifter, msb first
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_sh_q    <= `LXF_FLAG;
			tx_bit_q   <= 3'h0;
			tx_data_q  <= 1'b0;
			tx_bsync_q <= 1'b0;
		end
		else if (tx_edge)
		begin
			tx_sh_q    <= tx_load ? {tx_out[6:0], 1'b0} : {tx_sh_q[6:0], 1'b0};
			tx_bit_q   <= tx_bit_q + 3'h1;
			// [RULE_03] scrambling last
			tx_data_q  <= scr_en ? (tx_line_bit ^ tx_scr_q[42]) : tx_line_bit;
			tx_bsync_q <= tx_load;
		end
	end

	// [RULE_06] [RULE_23] self-synchronous descrambler
	assign rx_clear_bit = scr_en ? (rxd_sync_q[1] ^ rx_scr_q[42]) : rxd_sync_q[1];
	always @(posedge pclk)
	begin
		if (rx_edge)
			rx_scr_q <= {rx_scr_q[41:0], rxd_sync_q[1]};
	end
	assign rx_line_bit = rx_clear_bit;

	// receive octet assembly aligned to byte sync
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_sh_q  <= 8'h00;
			rx_bit_q <= 3'h0;
		end
		else if (rx_edge)
		begin
			rx_sh_q  <= {rx_sh_q[6:0], rx_line_bit};
			rx_bit_q <= rxb_sync_q[1] ? 3'h1 : rx_bit_q + 3'h1;
		end
	end
	assign rx_byte_ev = rx_edge & (rxb_sync_q[1] ? 1'b0 : (rx_bit_q == 3'h7));

	// receive octet classification
	always @*
	begin
		rx_byte = {rx_sh_q[6:0], rx_line_bit};
		// [RULE_08] unescape
		if (rx_esc_q & (rx_byte == `LXF_ESC_7E))
			rx_byte = `LXF_FLAG;
		else if (rx_esc_q & (rx_byte == `LXF_ESC_7D))
			rx_byte = `LXF_ESC;
	end
	assign rx_data_ev  = rx_byte_ev & (rx_st_q == RS_IN) & ~rx_bad_q &
		(rx_esc_q ? (({rx_sh_q[6:0], rx_line_bit} == `LXF_ESC_7E) |
		({rx_sh_q[6:0], rx_line_bit} == `LXF_ESC_7D)) :
		(rx_byte != `LXF_ESC) & (rx_byte != `LXF_FLAG));
	// [RULE_06] closing flag ends the frame
	assign rx_end      = rx_byte_ev & (rx_st_q == RS_IN) & ~rx_esc_q &
		(rx_byte == `LXF_FLAG) & (rx_cnt_q != 16'h0000);
	// [RULE_09] header mismatch
	assign rx_hdr_bad  = rx_data_ev & (rx_cnt_q < 16'h0004) &
		(rx_byte != lxf_hdr_byte(hdr_q, rx_cnt_q[2:0]));
	// [RULE_10] [RULE_13] bad escape pairs; [RULE_07] 7D DD dropped
	assign rx_abort_ev = rx_byte_ev & (rx_st_q == RS_IN) & rx_esc_q &
		({rx_sh_q[6:0], rx_line_bit} != `LXF_ESC_7E) &
		({rx_sh_q[6:0], rx_line_bit} != `LXF_ESC_7D) &
		({rx_sh_q[6:0], rx_line_bit} != `LXF_RATE_ADAPT);

	lxf_crc32 u_rx_crc (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (rx_byte_ev & (rx_byte == `LXF_FLAG) & ~rx_esc_q),
		.en      (rx_data_ev),
		.din     (rx_byte),
		.crc_q   (),
		.good    (rx_crc_good)
	);

	// receive sequencer and queue output
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_st_q    <= RS_HUNT;
			rx_esc_q   <= 1'b0;
			rx_cnt_q   <= 16'h0000;
			rx_bad_q   <= 1'b0;
			rxq_valid  <= 1'b0;
			rxq_data   <= 8'h00;
			rxq_last   <= 1'b0;
			rxq_abort  <= 1'b0;
			rx_good_q  <= 16'h0000;
			rx_abort_q <= 16'h0000;
		end
		else
		begin
			rxq_valid <= 1'b0;
			rxq_last  <= 1'b0;
			rxq_abort <= 1'b0;
			if (rx_byte_ev)
			begin
				rx_esc_q <= ~rx_esc_q & (rx_byte == `LXF_ESC) & (rx_st_q == RS_IN);
				// [RULE_06] hunt for opening flag
				if ((rx_st_q == RS_HUNT) & (rx_byte == `LXF_FLAG))
				begin
					rx_st_q  <= RS_IN;
					rx_cnt_q <= 16'h0000;
					rx_bad_q <= 1'b0;
				end
			end
			if (rx_data_ev)
			begin
				rx_cnt_q <= rx_cnt_q + 16'h0001;
				if (rx_cnt_q >= 16'h0004)
				begin
					rxq_valid <= 1'b1;
					rxq_data  <= rx_byte;
				end
			end
			if (rx_hdr_bad | rx_abort_ev | rx_end)
			begin
				// [RULE_24] end marker with abort flag
				rxq_valid <= 1'b1;
				rxq_last  <= 1'b1;
				rxq_data  <= 8'h00;
				// [RULE_11] [RULE_12] fcs and length checks
				rxq_abort <= rx_hdr_bad | rx_abort_ev | rx_bad_q | ~rx_crc_good |
					(rx_cnt_q < `LXF_MIN_OCTETS);
				if (rx_hdr_bad | rx_abort_ev | rx_bad_q | ~rx_crc_good |
					(rx_cnt_q < `LXF_MIN_OCTETS))
					rx_abort_q <= rx_abort_q + 16'h0001;
				else
					rx_good_q <= rx_good_q + 16'h0001;
				rx_cnt_q <= 16'h0000;
				rx_bad_q <= 1'b0;
				rx_st_q  <= rx_end ? RS_IN : RS_HUNT;
				if (!rx_end)
					rx_esc_q <= 1'b0;
			end
		end
	end
endmodule // lxf_framer

/* lxf_defs.vh */
// Purpose: constants for the lap framer with rate controller
// Assumes: 40 MHz pclk, APB register access, byte-synchronous serial line
// Notes: included by every design file of the framer
// Notes on behaviour
// [RULE_01] laps mode bit set: every outgoing frame gets lap framing.
// [RULE_02] frame is flag, address, control, sapi, mac data, then 32 bit fcs.
// [RULE_03] order: build, fcs, escaping, closing flag, then optional scrambling.
// [RULE_04] transmit body octet 7E becomes 7D 5E, octet 7D becomes 7D 5D.
// [RULE_05] each transmitted frame ends with one 7E flag.
// [RULE_06] receiver descrambles, hunts for 7E opening flag, ends at closing flag.
// [RULE_07] receiver deletes rate adaptation pair 7D DD.
// [RULE_08] receiver turns 7D 5E into 7E and 7D 5D into 7D.
// [RULE_09] received address, control and sapi must match programmed values, else abort.
// [RULE_10] received 7D 7E aborts the frame.
// [RULE_11] frame with bad fcs is aborted.
// [RULE_12] frame shorter than 6 octets is aborted.
// [RULE_13] 7D followed by anything but 5D, 5E, 7E, DD aborts.
// [RULE_14] rate control limits only mac-to-serial traffic.
// [RULE_15] committed rate in 500 kbps steps, 0 to 52 Mbps.
// [RULE_16] transmitter requests a frame only while credit is positive.
// [RULE_17] after each frame, credit drops by the frame size in bytes.
// [RULE_18] every 125 ms credit grows by the rate over eight.
// [RULE_19] credit unused for 250 ms is cleared to zero.
// [RULE_20] credit never goes negative; no frame leaves without credit.
// [RULE_21] software keeps the committed rate at or below the line rate.
// [RULE_22] queue above high watermark raises flow control toward ethernet; the code also raises it with the level equal to the watermark.
// [RULE_23] scrambler is x^43+1, free running, never reset.
// [RULE_24] aborted receive frame reaches the queue with an abort marker.
`ifndef LXF_DEFS_VH
`define LXF_DEFS_VH
// register byte offsets
`define LXF_OFF_CTRL      12'h000
`define LXF_OFF_HDR       12'h004
`define LXF_OFF_CIR       12'h008
`define LXF_OFF_WMARK     12'h00C
`define LXF_OFF_CREDIT    12'h010
`define LXF_OFF_RXSTAT    12'h014
// control fields
`define LXF_CTRL_LAPS     0
`define LXF_CTRL_SCR      1
// reset values
`define LXF_RST_CTRL      2'h0
`define LXF_RST_HDR       32'h00000000
`define LXF_RST_CIR       7'h00
`define LXF_RST_WMARK     16'hFFFF
// rate setting: 500 kbps units, top 52 Mbps
`define LXF_CIR_MAX       7'h68
`define LXF_CIR_STEP_BPS  500000
// credit period and expiry
`define LXF_CLK_HZ        40000000
`define LXF_TICK_MS       125
`define LXF_CLEAR_MS      250
`define LXF_TICK_CYCLES   (`LXF_TICK_MS * (`LXF_CLK_HZ / 1000))
`define LXF_CLEAR_TICKS   (`LXF_CLEAR_MS / `LXF_TICK_MS)
// octets
`define LXF_FLAG          8'h7E
`define LXF_ESC           8'h7D
`define LXF_ESC_7E        8'h5E
`define LXF_ESC_7D        8'h5D
`define LXF_RATE_ADAPT    8'hDD
`define LXF_ESC_XOR       8'h20
`define LXF_MIN_OCTETS    16'h0006
`define LXF_HDR_OCTETS    3'h4
// fcs
`define LXF_CRC_POLY      32'hEDB88320
`define LXF_CRC_INIT      32'hFFFFFFFF
`define LXF_CRC_RESIDUE   32'hDEBB20E3
`endif

/* lxf_crc32.v */
// Purpose: byte-wide 32 bit fcs engine
// Assumes: bits of each octet taken lsb first
// Notes: good flags the fixed residue after the fcs octets
`timescale 1ns/1ps
`include "lxf_defs.vh"
module lxf_crc32
(
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// control and data
	input  wire        clr,
	input  wire        en,
	input  wire [7:0]  din,
	// result
	output reg  [31:0] crc_q,
	output wire        good
);
	// one octet through the reflected polynomial
	function [31:0] lxf_crc_byte;
		input [31:0] c;
		input [7:0]  d;
		integer      i;
		reg   [31:0] r;
		begin
			r = c;
			for (i = 0; i < 8; i = i + 1)
				r = (r[0] ^ d[i]) ? ((r >> 1) ^ `LXF_CRC_POLY) : (r >> 1);
			lxf_crc_byte = r;
		end
	endfunction

	// running remainder
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			crc_q <= `LXF_CRC_INIT;
		else if (clr)
			crc_q <= `LXF_CRC_INIT;
		else if (en)
			crc_q <= lxf_crc_byte(crc_q, din);
	end

	assign good = (crc_q == `LXF_CRC_RESIDUE);
endmodule // lxf_crc32

/* lxf_cir.v */
// Purpose: committed rate credit counter
// Assumes: debit pulses once per sent frame
// Notes: credit saturates at all ones
`timescale 1ns/1ps
`include "lxf_defs.vh"
module lxf_cir
#(
	parameter TICK_CYCLES = `LXF_TICK_CYCLES
)
(
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// setting and debit
	input  wire [6:0]  cir,
	input  wire        debit,
	input  wire [15:0] debit_bytes,
	// state
	output reg  [23:0] credit_q,
	output wire        credit_ok
);
	reg  [31:0] tick_cnt_q;
	reg  [1:0]  idle_q;
	reg  [23:0] credit_d;
	reg  [24:0] sum;
	wire        tick;
	wire [20:0] prod;

	// period timer
	assign tick = (tick_cnt_q == TICK_CYCLES - 1);
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tick_cnt_q <= 32'h00000000;
		else if (tick)
			tick_cnt_q <= 32'h00000000;
		else
			tick_cnt_q <= tick_cnt_q + 32'h00000001;
	end

	// twice the rate times 500k, times 125 ms, over 8 bits per byte
	assign prod = cir * 21'h03D09;

	// credit update
	always @*
	begin
		sum = 25'h000000;
		// [RULE_17] debit frame size
		// [RULE_20] floor at zero
		if (debit)
			credit_d = (credit_q > {8'h00, debit_bytes}) ?
				(credit_q - {8'h00, debit_bytes}) : 24'h000000;
		else
			credit_d = credit_q;
		if (tick)
		begin
			// [RULE_19] stale credit cleared
			if (!debit && (idle_q == `LXF_CLEAR_TICKS - 1))
				credit_d = 24'h000000;
			// [RULE_18] periodic rate grant
			sum = {1'b0, credit_d} + {5'h00, prod[20:1]};
			credit_d = sum[24] ? 24'hFFFFFF : sum[23:0];
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			credit_q <= 24'h000000;
			idle_q   <= 2'h0;
		end
		else
		begin
			credit_q <= credit_d;
			if (debit)
				idle_q <= 2'h0;
			else if (tick)
				idle_q <= (idle_q == `LXF_CLEAR_TICKS - 1) ? 2'h0 : idle_q + 2'h1;
		end
	end

	// [RULE_16] request only on positive balance
	assign credit_ok = (credit_q != 24'h000000);
endmodule // lxf_cir

/* lxf_framer_chk_sva.sv */
// Purpose: port properties of the lap framer
// Assumes: one pclk domain, async active-low reset
// Notes: serial clocks are sampled inputs, not domains
`timescale 1ns/1ps
module lxf_framer_chk
(
	// clock and reset
	input logic		pclk,
	input logic		presetn,
	// apb
	input logic		psel,
	input logic		penable,
	input logic		pslverr,
	// mac queues
	input logic		txq_valid,
	input logic		txq_ready,
	input logic [15:0]	txq_level,
	input logic		eth_flow_ctrl,
	input logic		rxq_valid,
	input logic		rxq_last,
	input logic		rxq_abort,
	// serial out
	input logic		tx_bsync_q
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// end marker of a received frame
	sequence s_marker;
		rxq_valid && rxq_last;
	endsequence
	property p_ready_gap;
		txq_ready |=> !txq_ready [*8];
	endproperty
	a_ready_gap: assert property (p_ready_gap)
		else $error("tx bytes taken too close");
	property p_ready_valid;
		txq_ready |-> txq_valid;
	endproperty
	a_ready_valid: assert property (p_ready_valid)
		else $error("tx byte taken while queue empty");
	property p_bsync_gap;
		$rose(tx_bsync_q) |=> !$rose(tx_bsync_q) [*8];
	endproperty
	a_bsync_gap: assert property (p_bsync_gap)
		else $error("octet sync too close");
	property p_rx_pulse;
		rxq_valid |=> !rxq_valid;
	endproperty
	a_rx_pulse: assert property (p_rx_pulse)
		else $error("rx strobe held");
	property p_abort_last;
		rxq_abort |-> s_marker;
	endproperty
	a_abort_last: assert property (p_abort_last)
		else $error("abort without end marker");
	property p_last_valid;
		rxq_last |-> rxq_valid;
	endproperty
	a_last_valid: assert property (p_last_valid)
		else $error("end marker without strobe");
	property p_flow_full;
		txq_level == 16'hFFFF |-> eth_flow_ctrl;
	endproperty
	a_flow_full: assert property (p_flow_full)
		else $error("full queue without flow control");
	property p_err_phase;
		pslverr |-> psel && penable;
	endproperty
	a_err_phase: assert property (p_err_phase)
		else $error("slave error outside access");
endmodule // lxf_framer_chk

bind lxf_framer lxf_framer_chk u_lxf_framer_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pslverr(pslverr), .txq_valid(txq_valid),
	.txq_ready(txq_ready), .txq_level(txq_level), .eth_flow_ctrl(eth_flow_ctrl),
	.rxq_valid(rxq_valid), .rxq_last(rxq_last), .rxq_abort(rxq_abort),
	.tx_bsync_q(tx_bsync_q));

/* lxf_line_model.sv */
// Purpose: serial line partner of the framer
// Assumes: byte sync marks the msb of each octet
// Notes: sends idle flags when it has nothing queued
`timescale 1ns/1ps
module lxf_line_model
(
	// line clocks
	output logic	tx_clk,
	output logic	rx_clk,
	// toward the framer
	output logic	rx_data,
	output logic	rx_bsync,
	// from the framer
	input logic	tx_data_q,
	input logic	tx_bsync_q
);
	logic [7:0]	send_q[$];
	logic [7:0]	seen_q[$];
	logic [7:0]	sh;
	logic [7:0]	cap;
	int		bitn;
	int		capn;
	// free running clocks off the pclk grid
	initial
	begin
		tx_clk = 0;
		rx_clk = 0;
		rx_data = 0;
		rx_bsync = 0;
		bitn = 0;
		capn = 0;
		fork
			begin #7; forever #100 tx_clk = ~tx_clk; end
			begin #33; forever #100 rx_clk = ~rx_clk; end
		join
	end
	// octets out msb first, flags when idle
	always @(negedge rx_clk)
	begin
		if (bitn == 0)
			sh = (send_q.size() > 0) ? send_q.pop_front() : 8'h7E;
		rx_data = sh[7 - bitn];
		rx_bsync = (bitn == 0);
		bitn = (bitn + 1) % 8;
	end
	// octet capture aligned on byte sync
	always @(posedge tx_clk)
	begin
		if (tx_bsync_q === 1'b1)
			{cap, capn} = {7'h00, tx_data_q, 32'd1};
		else if (capn > 0)
			{cap, capn} = {cap[6:0], tx_data_q, capn + 32'd1};
		if (capn == 8)
			seen_q.push_back(cap);
	end
endmodule // lxf_line_model

/* tb_top.sv */
// Purpose: register, transmit and receive tests of the framer
// Assumes: short credit period of 2000 pclk
// Notes: frames built here with a bench-side fcs
`timescale 1ns/1ps
module tb_top;
	logic		pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0]	paddr;
	logic [31:0]	pwdata, prdata, r, fc;
	logic		txq_valid, txq_last, txq_ready, tx_frame_req, eth_flow_ctrl;
	logic [7:0]	txq_data, rxq_data;
	logic [15:0]	txq_level;
	logic		rxq_valid, rxq_last, rxq_abort, tx_clk, tx_data_q, tx_bsync_q;
	logic		rx_clk, rx_data, rx_bsync;
	logic [7:0]	rxd[$], f[$], g[$];
	logic		mk[$];
	int		miscompares, check_count, rdy_n, cyc, n, k;
	lxf_framer #(.TICK_CYCLES(2000)) u_lxf_framer (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .txq_valid(txq_valid),
		.txq_data(txq_data), .txq_last(txq_last), .txq_level(txq_level),
		.txq_ready(txq_ready), .tx_frame_req(tx_frame_req), .eth_flow_ctrl(eth_flow_ctrl),
		.rxq_valid(rxq_valid), .rxq_data(rxq_data), .rxq_last(rxq_last),
		.rxq_abort(rxq_abort), .tx_clk(tx_clk), .tx_data_q(tx_data_q),
		.tx_bsync_q(tx_bsync_q), .rx_clk(rx_clk), .rx_data(rx_data), .rx_bsync(rx_bsync));
	lxf_line_model u_lxf_line_model (.tx_clk(tx_clk), .rx_clk(rx_clk), .rx_data(rx_data),
		.rx_bsync(rx_bsync), .tx_data_q(tx_data_q), .tx_bsync_q(tx_bsync_q));
	// clock, hang guard and output capture
	initial pclk = 0;
	always #12.5 pclk = ~pclk;
	always @(posedge pclk)
	begin
		cyc++;
		rdy_n += (txq_ready === 1'b1);
		if (rxq_valid === 1'b1 && rxq_last === 1'b1)
			mk.push_back(rxq_abort);
		else if (rxq_valid === 1'b1)
			rxd.push_back(rxq_data);
		if (cyc == 40000)
		begin
			miscompares++;
			end_sim();
		end
	end
	task end_sim;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] x);
		check_count++;
		if (seen !== x)
		begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, x, seen);
		end
	endtask
	// one apb transfer, waits on pready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
		{r, e} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask
	task rdc(input string nm, input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(nm, r, x);
	endtask
	// frame: flag, escaped content and fcs, flag
	task build(input logic [7:0] c[$]);
		fc = 32'hFFFFFFFF;
		foreach (c[i])
		begin
			fc ^= c[i];
			repeat (8) fc = fc[0] ? (fc >> 1) ^ 32'hEDB88320 : fc >> 1;
		end
		fc = ~fc;
		f = {8'h7E};
		for (int i = 0; i < c.size() + 4; i++)
		begin
			r[7:0] = (i < c.size()) ? c[i] : fc[8 * (i - c.size()) +: 8];
			f = (r[7:0] == 8'h7E || r[7:0] == 8'h7D) ? {f, 8'h7D, r[7:0] ^ 8'h20} : {f, r[7:0]};
		end
		f.push_back(8'h7E);
	endtask
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = 0;
		{txq_valid, txq_data, txq_last, txq_level} = {10'h0, 16'hFFFF};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdc("ctrl", 12'h000, 32'h0);
		rdc("wmark", 12'h00C, 32'h0000FFFF);
		rdc("unmapped", 12'h040, 32'h0);
		chk("slverr", e, 32'h1);
		apb(1'b1, 12'h00C, 32'h10);
		txq_level <= 16'h000F;
		@(negedge pclk);
		chk("flow below", eth_flow_ctrl, 32'h0);
		@(posedge pclk);
		txq_level <= 16'h0010;
		@(negedge pclk);
		chk("flow at", eth_flow_ctrl, 32'h1);
		$display("test registers done");
		// no credit: nothing leaves
		apb(1'b1, 12'h004, 32'h01FE0304);
		apb(1'b1, 12'h000, 32'h1);
		{txq_valid, txq_data} <= 9'h17E;
		repeat (2500) @(posedge pclk);
		chk("req", tx_frame_req, 32'h0);
		chk("taken", rdy_n, 32'h0);
		rdc("credit", 12'h010, 32'h0);
		u_lxf_line_model.seen_q.delete();
		apb(1'b1, 12'h008, 32'h2);
		g = {8'h04, 8'h03, 8'hFE, 8'h01, 8'h7E, 8'h7D, 8'h41};
		build(g);
		for (int i = 4; i < 7; i++)
		begin
			{txq_data, txq_last} <= {g[i], i == 6};
			n = 0;
			do @(negedge pclk); while (txq_ready !== 1'b1 && ++n < 8000);
			@(posedge pclk);
		end
		txq_valid <= 1'b0;
		repeat (700) @(posedge pclk);
		rdc("credit debit", 12'h010, 32'd15622);
		k = 0;
		while (u_lxf_line_model.seen_q[k] === 8'h7E)
			k++;
		for (int i = 1; i < f.size(); i++)
			chk("tx octet", u_lxf_line_model.seen_q[k + i - 1], f[i]);
		repeat (4500) @(posedge pclk);
		rdc("credit expiry", 12'h010, 32'd15625);
		$display("test transmit done");
		// good frame with rate octets, then five faulty ones
		g = {8'h04, 8'h03, 8'hFE, 8'h01, 8'h7E, 8'h41};
		build(g);
		f.insert(7, 8'hDD);
		f.insert(7, 8'h7D);
		u_lxf_line_model.send_q = {f};
		k = fc;
		build({8'h04, 8'h03, 8'hFE, 8'h01, 8'h7E, 8'h41});
		f[7] = 8'h42;
		u_lxf_line_model.send_q = {u_lxf_line_model.send_q, f};
		build({8'h05, 8'h03, 8'hFE, 8'h01, 8'h41});
		u_lxf_line_model.send_q = {u_lxf_line_model.send_q, f, 8'h7E, 8'h04, 8'h03, 8'hFE,
			8'h01, 8'h41, 8'h7D, 8'h7E, 8'h7E, 8'h04, 8'h03, 8'hFE, 8'h01, 8'h7D, 8'h22,
			8'h7E, 8'h04, 8'h03, 8'h7E};
		n = 0;
		while (mk.size() < 6 && ++n < 20000)
			@(posedge pclk);
		chk("markers", mk.size(), 32'd6);
		chk("good", mk[0], 32'h0);
		chk("bad fcs", mk[1], 32'h1);
		chk("bad header", mk[2], 32'h1);
		chk("abort pair", mk[3], 32'h1);
		chk("bad escape", mk[4], 32'h1);
		chk("short", mk[5], 32'h1);
		chk("rx unescaped", rxd[0], 32'h7E);
		chk("rx after fill", rxd[1], 32'h41);
		for (int i = 0; i < 4; i++)
			chk("rx fcs", rxd[2 + i], k[8 * i +: 8]);
		rdc("rx counts", 12'h014, 32'h00050001);
		apb(1'b1, 12'h008, 32'h7F);
		rdc("cir clamp", 12'h008, 32'h68);
		$display("test receive done");
		end_sim();
	end
endmodule // tb_top
